// ===== rtl/chp_pkg.sv
package chp_pkg;

  // ==========================================================
  // Sizes
  localparam int CHP_NCH = 8;
  localparam int CHP_DLY_W = 5;
  localparam int CHP_STEP_W = 16;
  localparam int CHP_SLOTS = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] CHP_OFS_EN_MODE = 12'h000;
  localparam logic [11:0] CHP_OFS_FMASK = 12'h004;
  localparam logic [11:0] CHP_OFS_STEP = 12'h008;
  localparam logic [11:0] CHP_OFS_FLAGS = 12'h00C;
  localparam logic [11:0] CHP_OFS_STATUS = 12'h010;
  localparam logic [11:0] CHP_OFS_DLY0 = 12'h020;
  localparam logic [11:0] CHP_OFS_DLY_LAST = 12'h03C;

  // ==========================================================
  // Field positions in the flag register
  localparam int CHP_FLG_RESET_SEEN = 0;
  localparam int CHP_FLG_ENABLE_LOW = 1;
  localparam int CHP_FLG_SYNC_SEEN = 2;

  // Field positions in the status register
  localparam int CHP_STS_CHAN_LSB = 0;
  localparam int CHP_STS_FAULT = 8;
  localparam int CHP_STS_ENABLE = 9;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CHP_RST_EN_MODE = 8'h00;
  localparam logic [7:0] CHP_RST_FMASK = 8'h00;
  localparam logic [15:0] CHP_RST_STEP = 16'h0138;
  localparam logic [4:0] CHP_RST_DLY = 5'h00;

endpackage

// ===== rtl/chp_sync.sv
`timescale 1ns/10ps

module chp_sync import chp_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // ==========================================================
  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= din; // R05
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// ===== rtl/chp_phase.sv
`timescale 1ns/10ps

module chp_phase import chp_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic restart,
  input wire logic [CHP_STEP_W-1:0] step,
  input wire logic [CHP_DLY_W-1:0] delay,
  output logic period_start
);

  logic [CHP_STEP_W-1:0] sub_ff;
  logic [CHP_DLY_W-1:0] slot_ff;
  logic period_start_ff;
  logic last_sub;

  // One slot is step clocks; a period is 32 slots
  assign last_sub = (sub_ff >= step - 16'h0001) || (step == 16'h0000);

  // ==========================================================
  // Period timer; a restart places the timer delay slots before a period edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      sub_ff <= '0;
      slot_ff <= '0;
    end else if (restart) begin
      sub_ff <= '0; // R11
      slot_ff <= 5'h00 - delay; // R08
    end else if (last_sub) begin
      sub_ff <= '0;
      slot_ff <= slot_ff + 5'h01;
    end else begin
      sub_ff <= sub_ff + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      period_start_ff <= 1'b0;
    end else begin
      period_start_ff <= (slot_ff == 5'h00) && (sub_ff == 16'h0000) && !restart; // R07
    end
  end

  assign period_start = period_start_ff;

endmodule

// ===== rtl/chp_top.sv
`timescale 1ns/10ps

// What this block does
// [R01] Internal supply-monitor reset turns all channels off and restores register defaults.
// [R02] While reset pin is low, channels stay off and registers hold defaults.
// [R03] Enable low: each channel turns off or holds, per its behaviour bit.
// [R04] Behaviour bits reset to turn-off on enable low.
// [R05] Serial clock is fully asynchronous to the master clock.
// [R06] All timing derives from the master clock, which must keep running.
// [R07] Each channel has its own phase delay register.
// [R08] Phase delay equals offset times one thirty-second of the PWM period.
// [R09] Every sync pulse sets a latched flag readable by software.
// [R10] Reading the flag register clears the sync flag.
// [R11] A sync rising edge restarts all PWM periods with their delays.
// [R12] Host pulses sync after reset release to align channel periods.
// [R13] Fault pin pulled low while any unmasked fault is present.
// [R14] Per-fault masks are software written.
// [R15] Reset pin falling edge latches reset-seen flag; read clears it.
// [R16] Enable low latches a flag; clears on read once enable is high.
// [R17] Reset, enable and sync pins are synchronised; sync edges found after.
module chp_top import chp_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic enable_pin,
  input wire logic phase_sync_pin,
  input wire logic [CHP_NCH-1:0] chan_req,
  input wire logic [CHP_NCH-1:0] fault_in,
  output logic [CHP_NCH-1:0] chan_on,
  output logic [CHP_NCH-1:0] pwm_start,
  output logic fault_pin_out,
  output logic fault_pin_oe,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================================
  // Pin synchronisers
  logic rst_pin_n_s;
  logic enable_s;
  logic sync_s;
  logic sync_d_ff;
  logic rst_pin_d_ff;
  logic sync_rise;
  logic rst_fall;
  logic soft_reset;

  chp_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_rst (
    .mclk(mclk),
    .reset(reset),
    .din(reset_pin_n),
    .dout(rst_pin_n_s)
  ); // R17

  // Enable starts high so a reset alone does not latch the enable-low flag
  chp_sync #(.WIDTH(2), .INIT(2'b10)) u_sync_pins (
    .mclk(mclk),
    .reset(reset),
    .din({enable_pin, phase_sync_pin}),
    .dout({enable_s, sync_s})
  ); // R17

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_d_ff <= 1'b0;
      rst_pin_d_ff <= 1'b1;
    end else begin
      sync_d_ff <= sync_s;
      rst_pin_d_ff <= rst_pin_n_s;
    end
  end

  assign sync_rise = sync_s && !sync_d_ff; // R17
  assign rst_fall = rst_pin_d_ff && !rst_pin_n_s; // R15
  // Either reset source clears control state
  assign soft_reset = reset || !rst_pin_n_s; // R01 R02

  // ==========================================================
  // APB slave; answers in the first cycle of the access phase, with no wait state
  logic [7:0] en_mode_ff;
  logic [7:0] fmask_ff;
  logic [CHP_STEP_W-1:0] step_ff;
  logic [CHP_DLY_W-1:0] dly_ff [CHP_NCH];
  logic [2:0] flags;
  logic reset_seen_ff;
  logic enable_low_ff;
  logic sync_seen_ff;
  logic clr_reset_seen;
  logic clr_enable_low;
  logic clr_sync_seen;
  logic fault_out_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic setup;
  logic wr_done;
  logic rd_done;
  logic flags_read;
  logic [31:0] rd_val;
  logic rd_ok;
  logic fault_act_ff;
  logic [CHP_NCH-1:0] chan_on_ff;

  function automatic logic is_dly(input logic [11:0] a);
    is_dly = (a >= CHP_OFS_DLY0) && (a <= CHP_OFS_DLY_LAST) && (a[1:0] == 2'b00);
  endfunction

  function automatic int dly_idx(input logic [11:0] a);
    dly_idx = int'((a - CHP_OFS_DLY0) >> 2);
  endfunction

  assign setup = psel && !penable;
  assign wr_done = psel && penable && pready_ff && pwrite;
  assign rd_done = psel && penable && pready_ff && !pwrite;
  assign flags_read = rd_done && (paddr == CHP_OFS_FLAGS);

  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (paddr == CHP_OFS_EN_MODE) begin
      rd_val[7:0] = en_mode_ff;
    end else if (paddr == CHP_OFS_FMASK) begin
      rd_val[7:0] = fmask_ff;
    end else if (paddr == CHP_OFS_STEP) begin
      rd_val[CHP_STEP_W-1:0] = step_ff;
    end else if (paddr == CHP_OFS_FLAGS) begin
      rd_val[2:0] = flags;
    end else if (paddr == CHP_OFS_STATUS) begin
      rd_val[CHP_STS_CHAN_LSB +: CHP_NCH] = chan_on_ff;
      rd_val[CHP_STS_FAULT] = fault_act_ff;
      rd_val[CHP_STS_ENABLE] = enable_s;
    end else if (is_dly(paddr)) begin
      rd_val[CHP_DLY_W-1:0] = dly_ff[dly_idx(paddr)];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
    end
  end

  // Error strobe stands only in the access cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup && !rd_ok;
    end
  end

  // Read data is captured at the setup edge and stands through the access cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_ff <= 32'h00000000;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h00000000 : rd_val;
    end
  end

  // ==========================================================
  // Writable control registers
  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      en_mode_ff <= CHP_RST_EN_MODE; // R04
    end else if (wr_done && (paddr == CHP_OFS_EN_MODE)) begin
      en_mode_ff <= pwdata[7:0]; // R03
    end
  end

  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      fmask_ff <= CHP_RST_FMASK;
    end else if (wr_done && (paddr == CHP_OFS_FMASK)) begin
      fmask_ff <= pwdata[7:0]; // R14
    end
  end

  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      step_ff <= CHP_RST_STEP;
    end else if (wr_done && (paddr == CHP_OFS_STEP)) begin
      step_ff <= pwdata[CHP_STEP_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      for (int i = 0; i < CHP_NCH; i++) begin
        dly_ff[i] <= CHP_RST_DLY;
      end
    end else if (wr_done && is_dly(paddr)) begin
      dly_ff[dly_idx(paddr)] <= pwdata[CHP_DLY_W-1:0]; // R07
    end
  end

  // ==========================================================
  // Sticky flags; a new event in the clearing cycle wins
  // A read clears only what it reported, so an event between setup and access is kept
  assign clr_reset_seen = flags_read && prdata_ff[CHP_FLG_RESET_SEEN];
  assign clr_enable_low = flags_read && prdata_ff[CHP_FLG_ENABLE_LOW];
  assign clr_sync_seen = flags_read && prdata_ff[CHP_FLG_SYNC_SEEN];

  always_ff @(posedge mclk) begin
    if (reset) begin
      reset_seen_ff <= 1'b0;
    end else if (rst_fall) begin
      reset_seen_ff <= 1'b1; // R15
    end else if (clr_reset_seen) begin
      reset_seen_ff <= 1'b0; // R15
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_low_ff <= 1'b0;
    end else if (!enable_s) begin
      enable_low_ff <= 1'b1; // R16
    end else if (clr_enable_low) begin
      enable_low_ff <= 1'b0; // R16
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_seen_ff <= 1'b0;
    end else if (sync_rise) begin
      sync_seen_ff <= 1'b1; // R09
    end else if (clr_sync_seen) begin
      sync_seen_ff <= 1'b0; // R10
    end
  end

  // Flag word as software sees it
  always_comb begin
    flags = 3'h0;
    flags[CHP_FLG_RESET_SEEN] = reset_seen_ff;
    flags[CHP_FLG_ENABLE_LOW] = enable_low_ff;
    flags[CHP_FLG_SYNC_SEEN] = sync_seen_ff;
  end

  // ==========================================================
  // Channel gating by the enable pin
  // Hold mode keeps the output frozen, not following chan_req
  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      chan_on_ff <= '0; // R01 R02
    end else begin
      for (int i = 0; i < CHP_NCH; i++) begin
        if (enable_s) begin
          chan_on_ff[i] <= chan_req[i];
        end else if (!en_mode_ff[i]) begin
          chan_on_ff[i] <= 1'b0; // R03
        end
      end
    end
  end

  // ==========================================================
  // Fault pin: open drain, driven low while an unmasked fault exists
  always_ff @(posedge mclk) begin
    if (soft_reset) begin
      fault_act_ff <= 1'b0;
    end else begin
      fault_act_ff <= |(fault_in & ~fmask_ff); // R13
    end
  end

  // Driven level of the open-drain pin is always low; only its enable moves
  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_out_ff <= 1'b0;
    end else begin
      fault_out_ff <= 1'b0; // R13
    end
  end

  // ==========================================================
  // Per-channel PWM period timers, all on mclk
  genvar g;
  generate
    for (g = 0; g < CHP_NCH; g++) begin : g_ch
      chp_phase u_phase (
        .mclk(mclk),
        .reset(soft_reset),
        .restart(sync_rise),
        .step(step_ff),
        .delay(dly_ff[g]),
        .period_start(pwm_start[g])
      ); // R06 R11
    end
  endgenerate

  assign chan_on = chan_on_ff;
  assign fault_pin_out = fault_out_ff;
  assign fault_pin_oe = fault_act_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule

// ===== testbench/chp_checker.sv
`timescale 1ns/10ps

module chp_checker import chp_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic enable_pin,
  input wire logic phase_sync_pin,
  input wire logic [CHP_NCH-1:0] fault_in,
  input wire logic [CHP_NCH-1:0] chan_on,
  input wire logic [CHP_NCH-1:0] pwm_start,
  input wire logic fault_pin_out,
  input wire logic fault_pin_oe,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready
);
  // ==========
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_sync_rise;
    !phase_sync_pin ##1 phase_sync_pin;
  endsequence
  a_rst_chan_off: assert property (disable iff (1'b0) reset |=> chan_on == '0)
    else $error("channel on after supply reset");
  a_rst_fault_rel: assert property (disable iff (1'b0) reset |=> !fault_pin_oe)
    else $error("fault pin driven after supply reset");
  a_pin_rst_off: assert property (!reset_pin_n [*4] |=> chan_on == '0)
    else $error("channel on while reset pin low");
  a_fault_drive_lo: assert property (fault_pin_oe |-> fault_pin_out == 1'b0)
    else $error("fault pin driven high");
  a_fault_idle: assert property (fault_in == '0 |=> !fault_pin_oe)
    else $error("fault pin low without fault");
  a_apb_ready: assert property (s_setup |=> pready)
    else $error("no ready in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  // A held channel may stay on, but nothing may switch on while enable is low
  a_en_no_on: assert property (!enable_pin [*4] |=> (chan_on & ~$past(chan_on)) == '0)
    else $error("channel switched on while enable low");
  a_sync_start: assert property (s_sync_rise ##0 reset_pin_n |-> ##[2:6] pwm_start[0])
    else $error("no period start after sync edge");
endmodule

bind chp_top chp_checker i_chk (.mclk, .reset, .reset_pin_n, .enable_pin, .phase_sync_pin,
  .fault_in, .chan_on, .pwm_start, .fault_pin_out, .fault_pin_oe, .psel, .penable, .pready);

// ===== testbench/chp_host_pins.sv
`timescale 1ns/10ps

module chp_host_pins (
  input wire logic mclk,
  output logic reset_pin_n,
  output logic enable_pin,
  output logic phase_sync_pin
);
  // ==========
  // Pin drivers of the host
  initial begin
    reset_pin_n = 1'b1;
    enable_pin = 1'b1;
    phase_sync_pin = 1'b0;
  end
  // One clock high, then low again, so every edge is seen once
  task automatic sync_pulse();
    @(posedge mclk);
    phase_sync_pin <= 1'b1;
    @(posedge mclk);
    phase_sync_pin <= 1'b0;
  endtask
  task automatic set_pins(input logic rn, input logic en);
    @(posedge mclk);
    reset_pin_n <= rn;
    enable_pin <= en;
  endtask
endmodule

// ===== testbench/chp_top_tb_top.sv
`timescale 1ns/10ps

module chp_top_tb_top import chp_pkg::*;;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, fault_pin_out, fault_pin_oe;
  logic reset_pin_n, enable_pin, phase_sync_pin;
  logic [7:0] chan_req, fault_in, chan_on, pwm_start, s, m;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int n_tests = 0;
  int n;

  chp_top i_dut (.mclk, .reset, .reset_pin_n, .enable_pin, .phase_sync_pin, .chan_req,
    .fault_in, .chan_on, .pwm_start, .fault_pin_out, .fault_pin_oe, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  chp_host_pins i_host (.mclk, .reset_pin_n, .enable_pin, .phase_sync_pin);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] v);
    n_tests++;
    if (v !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, e, v);
    end
  endtask
  task automatic chk_rd(input logic [32:0] e, input logic [32:0] v);
    n_tests++;
    if (v !== e) begin
      error_cnt++;
      $display("unexpected read exp %h seen %h", e, v);
    end
  endtask
  // Read expectations hold {slave error, data}; the monitor pops them
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk_rd(exp_q.pop_front(), {pslverr, prdata});
  end

  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end

  // ==========
  // Scenarios
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    chan_req = 8'h00;
    fault_in = 8'h00;
    s = 8'h51;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    i_host.sync_pulse();
    repeat (4) @(posedge mclk);
    apb(1'b0, CHP_OFS_FLAGS, 32'h0, 33'h4);
    apb(1'b0, CHP_OFS_FLAGS, 32'h0, 33'h0);
    apb(1'b0, CHP_OFS_EN_MODE, 32'h0, 33'h0);
    apb(1'b0, CHP_OFS_STEP, 32'h0, {17'h0, CHP_RST_STEP});
    apb(1'b0, 12'h100, 32'h0, 33'h1_0000_0000);
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      m = s;
      s = lfsr(s);
      apb(1'b1, CHP_OFS_FMASK, {24'h0, m}, 33'h0);
      fault_in <= s;
      repeat (3) @(posedge mclk);
      chk_pin("fault_oe", {7'h0, |(s & ~m)}, {7'h0, fault_pin_oe});
      apb(1'b0, CHP_OFS_FMASK, 32'h0, {25'h0, m});
    end
    fault_in <= 8'h00;
    apb(1'b1, CHP_OFS_EN_MODE, 32'hF, 33'h0);
    chan_req <= 8'hFF;
    repeat (3) @(posedge mclk);
    chk_pin("chan_on", 8'hFF, chan_on);
    i_host.set_pins(1'b1, 1'b0);
    repeat (5) @(posedge mclk);
    chan_req <= 8'h00;
    repeat (3) @(posedge mclk);
    chk_pin("chan_hold", 8'h0F, chan_on);
    apb(1'b0, CHP_OFS_STATUS, 32'h0, 33'h00F);
    apb(1'b0, CHP_OFS_FLAGS, 32'h0, 33'h2);
    i_host.set_pins(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    apb(1'b0, CHP_OFS_FLAGS, 32'h0, 33'h2);
    apb(1'b0, CHP_OFS_FLAGS, 32'h0, 33'h0);
    chan_req <= 8'hFF;
    i_host.set_pins(1'b0, 1'b1);
    repeat (5) @(posedge mclk);
    chk_pin("chan_rst", 8'h00, chan_on);
    i_host.set_pins(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    apb(1'b0, CHP_OFS_EN_MODE, 32'h0, 33'h0);
    apb(1'b0, CHP_OFS_FLAGS, 32'h0, 33'h1);
    apb(1'b0, CHP_OFS_FLAGS, 32'h0, 33'h0);
    // Gap between channel 0 and 1 avoids guessing the sync latency itself
    apb(1'b1, CHP_OFS_DLY0 + 12'h4, 32'h3, 33'h0);
    apb(1'b1, CHP_OFS_STEP, 32'h2, 33'h0);
    i_host.sync_pulse();
    repeat (3) @(posedge mclk);
    while (pwm_start[0] !== 1'b1) @(posedge mclk);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pwm_start[1] !== 1'b1);
    chk_pin("phase_gap", 8'd6, n[7:0]);
    print_verdict();
  end
endmodule
